// ---- core/ptc_defs.svh ----
// Fixed levels, standard rates, timing constants and reset values for the trigger qualifier.
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// Logic-family switching thresholds in millivolt sample codes.
`define PTC_TTL_LEVEL 16'h0578
`define PTC_ECL_LEVEL 16'hfaec

// Bit rates in kb/s.
`define PTC_RATE_OC1 32'h0000ca80
`define PTC_RATE_OC3 32'h00025f80
`define PTC_RATE_OC12 32'h00097e00
`define PTC_RATE_MASK 32'h00000040
`define PTC_RATE_E1 32'h00000800
`define PTC_RATE_E2 32'h000020f8
`define PTC_RATE_E3 32'h00008640
`define PTC_RATE_E4 32'h00021ffc
`define PTC_RATE_E5 32'h00089f08

// Timing: clock period and the shortest edge slew qualification can resolve.
`define PTC_CLK_PS 8000
`define PTC_MIN_SLEW_PS 600
`define PTC_MIN_SLEW_CYC (((`PTC_MIN_SLEW_PS + `PTC_CLK_PS - 1) / `PTC_CLK_PS) < 1 ? 1 : \
	((`PTC_MIN_SLEW_PS + `PTC_CLK_PS - 1) / `PTC_CLK_PS))
`define PTC_AUTO_US 100
`define PTC_AUTO_CYC ((`PTC_AUTO_US * 1000000) / `PTC_CLK_PS)

// Reset values.
`define PTC_RST_LEVEL 16'h0000
`define PTC_RST_RATE 32'h00000000

`endif

// ---- core/ptc_peak_if.sv ----
// Carrier between the trigger qualifier and its peak tracker.
`timescale 1ns/1ps
interface ptc_peak_if import ptc_pkg::*; ();
	ptc_sample_t sample;
	ptc_sample_t mid_level;
	logic mid_valid;
	modport tracker (input sample, output mid_level, output mid_valid);
	modport user (output sample, input mid_level, input mid_valid);
endinterface : ptc_peak_if

// ---- core/ptc_peak_track.sv ----
// Peak tracker that reports the midpoint between the source's extremes each window.
`timescale 1ns/1ps
`include "ptc_defs.svh"
module ptc_peak_track import ptc_pkg::*; #(
	parameter int WINDOW = 1024
) (
	input wire logic clk,
	input wire logic rst,
	ptc_peak_if.tracker pk
);
	ptc_sample_t hi;
	ptc_sample_t lo;
	ptc_sample_t mid;
	logic valid;
	logic [31:0] cnt;
	ptc_sample_t next_hi;
	ptc_sample_t next_lo;
	ptc_sample_t next_mid;
	logic next_valid;
	logic [31:0] next_cnt;
	logic signed [16:0] sum;

	always_comb begin
		sum = 17'(hi) + 17'(lo);
		next_hi = (pk.sample > hi) ? pk.sample : hi;
		next_lo = (pk.sample < lo) ? pk.sample : lo;
		next_mid = mid;
		next_valid = valid;
		next_cnt = cnt + 32'h1;
		if (cnt == 32'(WINDOW - 1)) begin
			next_mid = ptc_sample_t'(sum >>> 1);
			next_valid = 1'b1;
			next_hi = pk.sample;
			next_lo = pk.sample;
			next_cnt = 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hi <= 16'h8000;
			lo <= 16'h7fff;
			mid <= `PTC_RST_LEVEL;
			valid <= 1'b0;
			cnt <= 32'h0;
		end else begin
			hi <= next_hi;
			lo <= next_lo;
			mid <= next_mid;
			valid <= next_valid;
			cnt <= next_cnt;
		end
	end

	assign pk.mid_level = mid;
	assign pk.mid_valid = valid;
endmodule : ptc_peak_track

// ---- core/ptc_pkg.sv ----
// Types shared by the trigger qualifier modules.
package ptc_pkg;
	`include "ptc_defs.svh"

	typedef logic signed [15:0] ptc_sample_t;
	typedef enum logic [1:0] {PTC_SRC_ONE = 2'h0, PTC_SRC_TWO = 2'h1, PTC_SRC_THREE = 2'h2,
		PTC_SRC_FOUR = 2'h3} ptc_src_t;
	typedef enum logic [1:0] {PTC_CLS_GLITCH = 2'h0, PTC_CLS_WIDTH = 2'h1,
		PTC_CLS_SLEW = 2'h2, PTC_CLS_TIMEOUT = 2'h3} ptc_class_t;
	typedef enum logic [1:0] {PTC_POL_POS = 2'h0, PTC_POL_NEG = 2'h1,
		PTC_POL_EITHER = 2'h2} ptc_pol_t;
	typedef enum logic [1:0] {PTC_LVL_MANUAL = 2'h0, PTC_LVL_TTL = 2'h1, PTC_LVL_ECL = 2'h2,
		PTC_LVL_MID = 2'h3} ptc_lvl_t;
	typedef enum logic [1:0] {PTC_CODE_NRZ = 2'h0, PTC_CODE_AMI = 2'h1, PTC_CODE_CMI = 2'h2,
		PTC_CODE_MASK = 2'h3} ptc_code_t;
	typedef enum logic [3:0] {PTC_STD_OC1 = 4'h0, PTC_STD_OC3 = 4'h1, PTC_STD_OC12 = 4'h2,
		PTC_STD_DS0_SGL = 4'h3, PTC_STD_DS0_DBL = 4'h4, PTC_STD_DS0_DATA = 4'h5,
		PTC_STD_DS0_TIMING = 4'h6, PTC_STD_E1 = 4'h7, PTC_STD_E2 = 4'h8, PTC_STD_E3 = 4'h9,
		PTC_STD_E4 = 4'ha, PTC_STD_E5 = 4'hb, PTC_STD_STM1E = 4'hc} ptc_std_t;
	typedef enum logic [1:0] {PTC_Z_LOW = 2'h0, PTC_Z_MID = 2'h1, PTC_Z_HIGH = 2'h2} ptc_zone_t;
	typedef enum logic [1:0] {PTC_SL_IDLE = 2'h0, PTC_SL_RISE = 2'h1,
		PTC_SL_FALL = 2'h2} ptc_slew_t;

	function automatic ptc_code_t ptc_std_code(input ptc_std_t s);
		unique case (s)
			PTC_STD_OC1, PTC_STD_OC3, PTC_STD_OC12, PTC_STD_E5: ptc_std_code = PTC_CODE_NRZ;
			PTC_STD_E1, PTC_STD_E2, PTC_STD_E3: ptc_std_code = PTC_CODE_AMI;
			PTC_STD_E4, PTC_STD_STM1E: ptc_std_code = PTC_CODE_CMI;
			default: ptc_std_code = PTC_CODE_MASK;
		endcase
	endfunction : ptc_std_code

	function automatic logic [31:0] ptc_std_rate(input ptc_std_t s);
		unique case (s)
			PTC_STD_OC1: ptc_std_rate = `PTC_RATE_OC1;
			PTC_STD_OC3, PTC_STD_STM1E: ptc_std_rate = `PTC_RATE_OC3;
			PTC_STD_OC12: ptc_std_rate = `PTC_RATE_OC12;
			PTC_STD_E1: ptc_std_rate = `PTC_RATE_E1;
			PTC_STD_E2: ptc_std_rate = `PTC_RATE_E2;
			PTC_STD_E3: ptc_std_rate = `PTC_RATE_E3;
			PTC_STD_E4: ptc_std_rate = `PTC_RATE_E4;
			PTC_STD_E5: ptc_std_rate = `PTC_RATE_E5;
			default: ptc_std_rate = `PTC_RATE_MASK;
		endcase
	endfunction : ptc_std_rate
endpackage : ptc_pkg

// ---- core/ptc_trigger.sv ----
// Pulse timeout, slew-rate and communications trigger qualification.
`timescale 1ns/1ps
`include "ptc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Slew trigger point at last crossed threshold
// - One source choice serves all classes
// - Held-high dwell past timeout fires
// - Held-low dwell past timeout fires
// - Either side dwell past timeout fires
// - Timeout is a programmed comparison limit
// - TTL preset replaces the trigger level
// - ECL preset replaces the trigger level
// - Midpoint preset uses centre between peaks
// - Mode and holdoff apply to every class
// - Comm trigger picks code and standard rate
// - Comm trigger forces needed acquisition settings
// - Mask loads comm settings, not reverse
// - TTL level is plus 1.4 volts
// - ECL level is minus 1.3 volts
// - Edges faster than 600 ps never qualify
module ptc_trigger import ptc_pkg::*; #(
	parameter int AUTO_CYCLES = `PTC_AUTO_CYC,
	parameter int PEAK_WINDOW = 1024
) (
	input wire logic clk,
	input wire logic rst,
	input wire ptc_sample_t input_channel_one,
	input wire ptc_sample_t input_channel_two,
	input wire ptc_sample_t input_channel_three,
	input wire ptc_sample_t input_channel_four,
	input wire ptc_src_t source_sel,
	input wire ptc_class_t pulse_class,
	input wire ptc_pol_t polarity,
	input wire ptc_lvl_t level_sel,
	input wire ptc_sample_t manual_level,
	input wire ptc_sample_t upper_threshold,
	input wire ptc_sample_t lower_threshold,
	input wire logic [31:0] delta_cycles,
	input wire logic trigger_if_faster,
	input wire logic [31:0] timeout_cycles,
	input wire logic auto_mode,
	input wire logic [31:0] holdoff_cycles,
	input wire logic comm_enable,
	input wire logic comm_select,
	input wire ptc_code_t comm_code_sel,
	input wire ptc_std_t comm_std_sel,
	input wire logic mask_load,
	input wire ptc_std_t mask_std,
	output logic trigger,
	output logic trigger_forced,
	output logic trig_at_upper,
	output ptc_sample_t trigger_level,
	output ptc_std_t comm_std,
	output ptc_code_t comm_code,
	output logic [31:0] comm_bit_rate,
	output logic mask_active,
	output ptc_std_t active_mask,
	output logic force_width_class,
	output logic force_midpoint_level
);
	////////////////////////////////////////////////////////////////////////////////
	// Source selection and level.
	ptc_sample_t chans [4];
	ptc_sample_t src;
	ptc_sample_t next_level;
	logic above;
	logic above_q;
	ptc_peak_if pk ();

	assign chans[0] = input_channel_one;
	assign chans[1] = input_channel_two;
	assign chans[2] = input_channel_three;
	assign chans[3] = input_channel_four;
	assign src = chans[source_sel];
	assign pk.sample = src;

	ptc_peak_track #(.WINDOW(PEAK_WINDOW)) u_peak (
		.clk(clk),
		.rst(rst),
		.pk(pk)
	);

	always_comb begin
		unique case (level_sel)
			PTC_LVL_MANUAL: next_level = manual_level;
			PTC_LVL_TTL: next_level = `PTC_TTL_LEVEL;
			PTC_LVL_ECL: next_level = `PTC_ECL_LEVEL;
			PTC_LVL_MID: next_level = pk.mid_valid ? pk.mid_level : trigger_level;
		endcase
	end

	assign above = src > trigger_level;

	////////////////////////////////////////////////////////////////////////////////
	// Timeout class.
	logic [31:0] dwell;
	logic armed;
	logic [31:0] next_dwell;
	logic next_armed;
	logic side_ok;
	logic to_hit;

	always_comb begin
		unique case (polarity)
			PTC_POL_POS: side_ok = above_q;
			PTC_POL_NEG: side_ok = !above_q;
			default: side_ok = 1'b1;
		endcase
		to_hit = (pulse_class == PTC_CLS_TIMEOUT) && armed && side_ok &&
			(dwell == timeout_cycles);
		next_dwell = (dwell == 32'hffffffff) ? dwell : dwell + 32'h1;
		next_armed = armed;
		if (above != above_q) begin
			next_dwell = 32'h0;
			next_armed = 1'b1;
		end else if (to_hit) begin
			next_armed = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slew-rate class.
	ptc_zone_t zone;
	ptc_zone_t zone_q;
	ptc_slew_t sl;
	ptc_slew_t next_sl;
	logic [31:0] sl_cnt;
	logic [31:0] next_sl_cnt;
	logic slew_hit;
	logic rate_ok;
	logic next_at_upper;

	always_comb begin
		if (src >= upper_threshold) begin
			zone = PTC_Z_HIGH;
		end else if (src < lower_threshold) begin
			zone = PTC_Z_LOW;
		end else begin
			zone = PTC_Z_MID;
		end
		rate_ok = trigger_if_faster ? (sl_cnt < delta_cycles) : (sl_cnt > delta_cycles);
		next_sl = sl;
		next_sl_cnt = sl_cnt + 32'h1;
		slew_hit = 1'b0;
		next_at_upper = trig_at_upper;
		unique case (sl)
			PTC_SL_IDLE: begin
				next_sl_cnt = 32'h0;
				if (zone == PTC_Z_MID && zone_q == PTC_Z_LOW && polarity != PTC_POL_NEG) begin
					next_sl = PTC_SL_RISE;
				end else if (zone == PTC_Z_MID && zone_q == PTC_Z_HIGH &&
					polarity != PTC_POL_POS) begin
					next_sl = PTC_SL_FALL;
				end
			end
			PTC_SL_RISE: begin
				if (zone != PTC_Z_MID) begin
					next_sl = PTC_SL_IDLE;
					if (zone == PTC_Z_HIGH && sl_cnt >= 32'(`PTC_MIN_SLEW_CYC - 1)) begin
						slew_hit = rate_ok;
						next_at_upper = 1'b1;
					end
				end
			end
			PTC_SL_FALL: begin
				if (zone != PTC_Z_MID) begin
					next_sl = PTC_SL_IDLE;
					if (zone == PTC_Z_LOW && sl_cnt >= 32'(`PTC_MIN_SLEW_CYC - 1)) begin
						slew_hit = rate_ok;
						next_at_upper = 1'b0;
					end
				end
			end
			default: next_sl = PTC_SL_IDLE;
		endcase
		if (pulse_class != PTC_CLS_SLEW) begin
			slew_hit = 1'b0;
			next_at_upper = trig_at_upper;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode and holdoff shared by every class.
	logic [31:0] hold_cnt;
	logic [31:0] auto_cnt;
	logic [31:0] next_hold_cnt;
	logic [31:0] next_auto_cnt;
	logic next_trigger;
	logic next_forced;
	logic raw_hit;

	always_comb begin
		raw_hit = to_hit || slew_hit;
		next_trigger = 1'b0;
		next_forced = 1'b0;
		next_hold_cnt = (hold_cnt != 32'h0) ? hold_cnt - 32'h1 : 32'h0;
		next_auto_cnt = auto_cnt + 32'h1;
		if (hold_cnt == 32'h0) begin
			if (raw_hit) begin
				next_trigger = 1'b1;
			end else if (auto_mode && auto_cnt >= 32'(AUTO_CYCLES - 1)) begin
				next_trigger = 1'b1;
				next_forced = 1'b1;
			end
		end
		if (next_trigger) begin
			next_hold_cnt = holdoff_cycles;
			next_auto_cnt = 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Communications settings.
	ptc_std_t next_std;
	logic next_mask_active;
	ptc_std_t next_mask;

	always_comb begin
		next_std = comm_std;
		next_mask_active = mask_active;
		next_mask = active_mask;
		if (mask_load) begin
			next_std = mask_std;
			next_mask_active = 1'b1;
			next_mask = mask_std;
		end else if (comm_select && (ptc_std_code(comm_std_sel) == comm_code_sel)) begin
			next_std = comm_std_sel;
		end
	end

	assign comm_code = ptc_std_code(comm_std);
	assign force_width_class = comm_enable && (comm_code == PTC_CODE_MASK);
	assign force_midpoint_level = comm_enable && (comm_code == PTC_CODE_AMI);

	////////////////////////////////////////////////////////////////////////////////
	// State registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			trigger_level <= `PTC_RST_LEVEL;
			above_q <= 1'b0;
			dwell <= 32'h0;
			armed <= 1'b1;
			zone_q <= PTC_Z_MID;
			sl <= PTC_SL_IDLE;
			sl_cnt <= 32'h0;
			trig_at_upper <= 1'b0;
			hold_cnt <= 32'h0;
			auto_cnt <= 32'h0;
			trigger <= 1'b0;
			trigger_forced <= 1'b0;
			comm_std <= PTC_STD_OC1;
			comm_bit_rate <= `PTC_RST_RATE;
			mask_active <= 1'b0;
			active_mask <= PTC_STD_DS0_SGL;
		end else begin
			trigger_level <= next_level;
			above_q <= above;
			dwell <= next_dwell;
			armed <= next_armed;
			zone_q <= zone;
			sl <= next_sl;
			sl_cnt <= next_sl_cnt;
			trig_at_upper <= next_at_upper;
			hold_cnt <= next_hold_cnt;
			auto_cnt <= next_auto_cnt;
			trigger <= next_trigger;
			trigger_forced <= next_forced;
			comm_std <= next_std;
			comm_bit_rate <= ptc_std_rate(next_std);
			mask_active <= next_mask_active;
			active_mask <= next_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence rise_done_s;
		sl == PTC_SL_RISE && zone == PTC_Z_HIGH && slew_hit;
	endsequence

	sequence fall_done_s;
		sl == PTC_SL_FALL && zone == PTC_Z_LOW && slew_hit;
	endsequence

	slew_upper_point_a: assert property (rise_done_s |=> trig_at_upper)
		else $error("slew trigger point not at upper threshold");
	slew_lower_point_a: assert property (fall_done_s |=> !trig_at_upper)
		else $error("slew trigger point not at lower threshold");
	timeout_high_a: assert property (to_hit && polarity == PTC_POL_POS |-> above_q &&
		dwell == timeout_cycles) else $error("held-high timeout fired off level");
	timeout_low_a: assert property (to_hit && polarity == PTC_POL_NEG |-> !above_q)
		else $error("held-low timeout fired off level");
	dwell_restart_a: assert property (above != above_q |=> dwell == 32'h0)
		else $error("dwell did not restart on a crossing");
	timeout_rearm_a: assert property (to_hit && above == above_q |=> !armed ##1
		(!to_hit || $past(above != above_q, 2) || $past(above != above_q)))
		else $error("timeout fired twice without a crossing");
	ttl_level_a: assert property (level_sel == PTC_LVL_TTL |=>
		trigger_level == `PTC_TTL_LEVEL) else $error("TTL level wrong");
	ecl_level_a: assert property (level_sel == PTC_LVL_ECL |=>
		trigger_level == `PTC_ECL_LEVEL) else $error("ECL level wrong");
	holdoff_load_a: assert property (trigger |-> hold_cnt == $past(holdoff_cycles))
		else $error("holdoff not loaded after a trigger");
	comm_no_mask_a: assert property (comm_select && !mask_load |=>
		active_mask == $past(active_mask) && mask_active == $past(mask_active))
		else $error("comm selection changed the mask");
endmodule : ptc_trigger

// ---- dv/ptc_chan_model.sv ----
// Behavioural model of the four channel feeds ahead of the trigger qualifier.
`timescale 1ns/1ps
module ptc_chan_model import ptc_pkg::*; (
	input wire logic clk,
	input wire ptc_src_t src,
	input wire ptc_sample_t val_a,
	input wire ptc_sample_t val_b,
	input wire logic alt,
	output ptc_sample_t ch_one,
	output ptc_sample_t ch_two,
	output ptc_sample_t ch_three,
	output ptc_sample_t ch_four
);
	ptc_sample_t pat = 16'h5a5a;
	ptc_sample_t sel_val;
	logic phase = 1'b0;

	// Unselected channels swing across zero every cycle so a wrong source never dwells.
	always @(negedge clk) begin
		phase <= ~phase;
		pat <= ~pat;
	end

	assign sel_val = (alt && phase) ? val_b : val_a;
	assign ch_one = (src == PTC_SRC_ONE) ? sel_val : pat;
	assign ch_two = (src == PTC_SRC_TWO) ? sel_val : pat;
	assign ch_three = (src == PTC_SRC_THREE) ? sel_val : pat;
	assign ch_four = (src == PTC_SRC_FOUR) ? sel_val : pat;
endmodule : ptc_chan_model

// ---- dv/pulse_timeout_comm_trigger_bench.sv ----
// Self-checking bench for the trigger qualifier.
`timescale 1ns/1ps
module pulse_timeout_comm_trigger_bench import ptc_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ptc_sample_t ch1, ch2, ch3, ch4;
	ptc_sample_t val_a = 16'h0000;
	ptc_sample_t val_b = 16'h0000;
	logic alt = 1'b0;
	ptc_src_t src = PTC_SRC_ONE;
	ptc_class_t cls = PTC_CLS_GLITCH;
	ptc_pol_t pol = PTC_POL_POS;
	ptc_lvl_t lvl = PTC_LVL_MANUAL;
	ptc_sample_t man_lvl = 16'h0000;
	logic [31:0] hold = 32'h00000000;
	logic auto_on = 1'b0;
	logic comm_en = 1'b0;
	logic comm_sel = 1'b0;
	logic mask_ld = 1'b0;
	logic faster = 1'b1;
	logic [31:0] tmo = 32'h00000005;
	ptc_code_t code_sel = PTC_CODE_NRZ;
	ptc_std_t std_sel = PTC_STD_OC1;
	ptc_std_t m_std = PTC_STD_OC1;
	logic trigger, trigger_forced, trig_at_upper, mask_active, fw, fm;
	ptc_sample_t trigger_level;
	ptc_std_t comm_std, active_mask;
	ptc_code_t comm_code;
	logic [31:0] comm_bit_rate;
	int n_mismatch = 0;
	int checked = 0;

	always #4 clk = ~clk;

	ptc_chan_model i_model (.clk(clk), .src(src), .val_a(val_a), .val_b(val_b), .alt(alt),
		.ch_one(ch1), .ch_two(ch2), .ch_three(ch3), .ch_four(ch4));

	ptc_trigger #(.AUTO_CYCLES(20), .PEAK_WINDOW(8)) i_dut (.clk(clk), .rst(rst),
		.input_channel_one(ch1), .input_channel_two(ch2), .input_channel_three(ch3),
		.input_channel_four(ch4), .source_sel(src), .pulse_class(cls), .polarity(pol),
		.level_sel(lvl), .manual_level(man_lvl), .upper_threshold(16'h03e8),
		.lower_threshold(16'h0064), .delta_cycles(32'h0000000a), .trigger_if_faster(faster),
		.timeout_cycles(tmo), .auto_mode(auto_on), .holdoff_cycles(hold),
		.comm_enable(comm_en), .comm_select(comm_sel), .comm_code_sel(code_sel),
		.comm_std_sel(std_sel), .mask_load(mask_ld), .mask_std(m_std), .trigger(trigger),
		.trigger_forced(trigger_forced), .trig_at_upper(trig_at_upper),
		.trigger_level(trigger_level), .comm_std(comm_std), .comm_code(comm_code),
		.comm_bit_rate(comm_bit_rate), .mask_active(mask_active), .active_mask(active_mask),
		.force_width_class(fw), .force_midpoint_level(fm));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic finish_test();
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic step(int n);
		repeat (n) @(negedge clk);
	endtask : step

	task automatic watch(int n, inout int cnt);
		repeat (n) begin
			@(posedge clk);
			#1 cnt += trigger;
		end
	endtask : watch

	task automatic wait_trig(inout int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
			#1;
		end while (trigger !== 1'b1 && n < 80);
	endtask : wait_trig

	////////////////////////////////////////////////////////////////////////////////
	// A gap restarts the dwell with one sample on the far side of the level.
	task automatic dwell_case(ptc_pol_t p, ptc_src_t s, ptc_sample_t a, ptc_sample_t b,
		bit gap, int t);
		int n;
		int extra = 0;
		@(negedge clk);
		tmo = 32'(t);
		cls = PTC_CLS_GLITCH;
		pol = p;
		src = s;
		val_a = a;
		step(4);
		cls = PTC_CLS_TIMEOUT;
		val_a = b;
		if (gap) begin
			watch(5, extra);
			@(negedge clk);
			val_a = a;
			@(negedge clk);
			val_a = b;
		end
		wait_trig(n);
		chk("timeout latency", n, 32'(t + 2));
		watch(12, extra);
		chk("extra triggers", extra, 0);
	endtask : dwell_case

	task automatic slew_case(ptc_pol_t p, ptc_sample_t a, ptc_sample_t m, ptc_sample_t b,
		int mids, logic exp, logic up, logic f);
		int seen = 0;
		@(negedge clk);
		faster = f;
		cls = PTC_CLS_SLEW;
		pol = p;
		val_a = a;
		step(3);
		if (mids > 0) begin
			val_a = m;
			step(mids);
		end
		val_a = b;
		watch(4, seen);
		chk("slew trigger", seen, exp);
		if (exp)
			chk("slew point", trig_at_upper, up);
	endtask : slew_case

	task automatic comm_case();
		ptc_std_t ss[4] = '{PTC_STD_E1, PTC_STD_OC12, PTC_STD_E4, PTC_STD_E3};
		ptc_code_t cs[4] = '{PTC_CODE_AMI, PTC_CODE_NRZ, PTC_CODE_CMI, PTC_CODE_AMI};
		logic [31:0] rs[4] = '{32'h00000800, 32'h00097e00, 32'h00021ffc, 32'h00008640};
		@(negedge clk);
		for (int i = 0; i < 5; i++) begin
			std_sel = (i < 4) ? ss[i] : PTC_STD_OC3;
			code_sel = (i < 4) ? cs[i] : PTC_CODE_AMI;
			comm_sel = 1'b1;
			step(1);
			comm_sel = 1'b0;
			chk("comm std", comm_std, ss[(i < 4) ? i : 3]);
			chk("comm code", comm_code, cs[(i < 4) ? i : 3]);
			chk("comm rate", comm_bit_rate, rs[(i < 4) ? i : 3]);
			chk("mask idle", mask_active, 1'b0);
			step(1);
		end
		comm_en = 1'b1;
		m_std = PTC_STD_DS0_DBL;
		mask_ld = 1'b1;
		step(1);
		mask_ld = 1'b0;
		chk("mask on", {mask_active, active_mask, comm_std}, 9'h144);
		chk("mask rate", comm_bit_rate, 32'h00000040);
		chk("forced", {fw, fm}, 2'h2);
		std_sel = PTC_STD_E1;
		comm_sel = 1'b1;
		step(1);
		comm_sel = 1'b0;
		chk("mask kept", {mask_active, active_mask, comm_std}, 9'h147);
		chk("forced ami", {fw, fm}, 2'h1);
		comm_en = 1'b0;
		step(1);
		chk("forced off", {fw, fm}, 2'h0);
	endtask : comm_case

	task automatic auto_case();
		int n;
		cls = PTC_CLS_GLITCH;
		auto_on = 1'b1;
		hold = 32'h0000001e;
		wait_trig(n);
		chk("auto forced", trigger_forced, 1'b1);
		wait_trig(n);
		chk("holdoff gap", n, 32'h0000001f);
		@(negedge clk);
		auto_on = 1'b0;
		hold = 32'h00000000;
	endtask : auto_case

	task automatic level_case();
		ptc_lvl_t ls[3] = '{PTC_LVL_MANUAL, PTC_LVL_TTL, PTC_LVL_ECL};
		ptc_sample_t ev[3] = '{16'h0123, 16'h0578, 16'hfaec};
		man_lvl = 16'h0123;
		foreach (ls[i]) begin
			lvl = ls[i];
			step(3);
			chk("level", trigger_level, ev[i]);
		end
		alt = 1'b1;
		val_a = 16'h0258;
		val_b = 16'hff38;
		lvl = PTC_LVL_MID;
		step(40);
		chk("mid level", trigger_level, 16'h00c8);
	endtask : level_case

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		step(12);
		chk("rst level", trigger_level, 16'h0000);
		chk("rst mask", {mask_active, active_mask, comm_std}, 9'h030);
		chk("rst rate", comm_bit_rate, 32'h00000000);
		rst = 1'b0;
		step(1);
		chk("rate", comm_bit_rate, 32'h0000ca80);
		dwell_case(PTC_POL_POS, PTC_SRC_ONE, 16'hfe0c, 16'h01f4, 1'b0, 5);
		dwell_case(PTC_POL_POS, PTC_SRC_THREE, 16'hfe0c, 16'h01f4, 1'b1, 5);
		dwell_case(PTC_POL_NEG, PTC_SRC_FOUR, 16'h01f4, 16'hfe0c, 1'b1, 5);
		dwell_case(PTC_POL_EITHER, PTC_SRC_TWO, 16'hfe0c, 16'h01f4, 1'b0, 5);
		dwell_case(PTC_POL_EITHER, PTC_SRC_TWO, 16'h01f4, 16'hfe0c, 1'b0, 8);
		slew_case(PTC_POL_POS, 16'h0000, 16'h01f4, 16'h07d0, 2, 1'b1, 1'b1, 1'b1);
		slew_case(PTC_POL_NEG, 16'h07d0, 16'h01f4, 16'h0000, 2, 1'b1, 1'b0, 1'b1);
		slew_case(PTC_POL_EITHER, 16'h0000, 16'h01f4, 16'h07d0, 0, 1'b0, 1'b0, 1'b1);
		slew_case(PTC_POL_POS, 16'h0000, 16'h01f4, 16'h07d0, 12, 1'b1, 1'b1, 1'b0);
		slew_case(PTC_POL_POS, 16'h0000, 16'h01f4, 16'h07d0, 2, 1'b0, 1'b1, 1'b0);
		comm_case();
		auto_case();
		level_case();
		finish_test();
	end

	initial begin
		#160000;
		n_mismatch++;
		finish_test();
	end
endmodule : pulse_timeout_comm_trigger_bench
